// *** rtl/prls_defs.svh ***
// constants shared by the pump rotation sequencer files
`ifndef PRLS_DEFS_SVH
`define PRLS_DEFS_SVH

// =============================================================
// sizes
`define PRLS_NUM_PUMPS      8
`define PRLS_IDX_W          3
`define PRLS_CNT_W          4
`define PRLS_SEC_W          16
`define PRLS_PRE_W          32

// =============================================================
// timing: clock rate in hertz and the derived ticks per second
`define PRLS_CLK_HZ         125000000
`define PRLS_SEC_S          1
`define PRLS_TICKS_PER_SEC  (`PRLS_CLK_HZ * `PRLS_SEC_S)

// =============================================================
// reset values
`define PRLS_RST_OUT        8'h00
`define PRLS_RST_ROT        3'h0
`define PRLS_RST_LEAD       4'h1
`define PRLS_RST_SECS       16'h0000
`define PRLS_RST_PRE        32'h0000_0000
`define PRLS_RANK_NONE      4'hF

`endif

// *** rtl/prls_pkg.sv ***
// types shared by the pump rotation sequencer files
`default_nettype none
`include "prls_defs.svh"

package prls_pkg;

	// =============================================================
	// sequencer and timer states
	typedef enum logic [0:0] {
		PRLS_SEQ_IDLE = 1'b0,
		PRLS_SEQ_WAIT = 1'b1
	} prls_seq_st_t;

	typedef enum logic [0:0] {
		PRLS_TMR_DONE = 1'b0,
		PRLS_TMR_RUN  = 1'b1
	} prls_tmr_st_t;

	// =============================================================
	// state records
	typedef struct packed {
		prls_seq_st_t                  st;
		logic [`PRLS_NUM_PUMPS-1:0]    out;
		logic [`PRLS_IDX_W-1:0]        rot;
		logic [`PRLS_CNT_W-1:0]        lead;
		logic                          armed;
	} prls_seq_state_t;

	typedef struct packed {
		prls_tmr_st_t                  st;
		logic [`PRLS_PRE_W-1:0]        pre;
		logic [`PRLS_SEC_W-1:0]        secs;
	} prls_tmr_state_t;

endpackage

`default_nettype wire

// *** rtl/prls_tmr_if.sv ***
// link between the sequencer and its switching delay timer
`timescale 1ns/10ps
`default_nettype none
`include "prls_defs.svh"

interface prls_tmr_if;
	logic                      clk;
	logic                      rst_n;
	logic                      restart;
	logic [`PRLS_SEC_W-1:0]    delay_sec;
	logic                      expired;
	logic [`PRLS_SEC_W-1:0]    secs_left;

	modport seq (
		output clk,
		output rst_n,
		output restart,
		output delay_sec,
		input  expired,
		input  secs_left
	);

	modport tmr (
		input  clk,
		input  rst_n,
		input  restart,
		input  delay_sec,
		output expired,
		output secs_left
	);
endinterface

`default_nettype wire

// *** rtl/prls_delay_timer.sv ***
// switching delay timer counting whole seconds
`timescale 1ns/10ps
`default_nettype none
`include "prls_defs.svh"

module prls_delay_timer #(
	parameter int unsigned TICKS_PER_SEC = `PRLS_TICKS_PER_SEC
)(
	prls_tmr_if.tmr t
);
	import prls_pkg::*;

	localparam logic [`PRLS_PRE_W-1:0] PRE_LAST =
		`PRLS_PRE_W'(TICKS_PER_SEC - 1);

	prls_tmr_state_t q;
	prls_tmr_state_t d;

	// =============================================================
	// next state: reload on restart, then count seconds down
	always_comb begin
		d = q;
		if (t.restart) begin
			d.st   = PRLS_TMR_RUN;
			d.secs = t.delay_sec;
			d.pre  = `PRLS_RST_PRE;
		end else begin
			unique case (q.st)
				PRLS_TMR_RUN: begin
					if (q.secs == `PRLS_RST_SECS) begin
						d.st = PRLS_TMR_DONE;
					end else if (q.pre == PRE_LAST) begin
						d.pre  = `PRLS_RST_PRE; // one-second enable
						d.secs = q.secs - 1'b1;
					end else begin
						d.pre = q.pre + 1'b1;
					end
				end
				PRLS_TMR_DONE: begin
					d.pre = `PRLS_RST_PRE;
				end
			endcase
		end
	end

	// =============================================================
	// state register; starts expired so the first step is not held
	always_ff @(posedge t.clk or negedge t.rst_n) begin
		if (!t.rst_n) begin
			q.st   <= PRLS_TMR_DONE;
			q.pre  <= `PRLS_RST_PRE;
			q.secs <= `PRLS_RST_SECS;
		end else begin
			q <= d;
		end
	end

	// =============================================================
	// outputs
	assign t.expired   = (q.st == PRLS_TMR_DONE);
	assign t.secs_left = q.secs;

endmodule

`default_nettype wire

// *** rtl/prls_pump_rotation_sequencer.sv ***
// lead/lag pump rotation sequencer for up to eight pumps
`timescale 1ns/10ps
`default_nettype none
`include "prls_defs.svh"

// Behaviour
// - Up to eight call inputs are taken and eight pump call outputs driven, one per pump relay.
// - As many outputs run as there are asserted calls on configured pumps, chosen in order starting at the lead pump.
// - Only the number of asserted calls matters, not which calls nor in what order they came.
// - No output turns on or off until the switching delay, set in seconds, has run out.
// - Every output switch restarts the switching delay.
// - A valid lead index makes that pump start first and stop last.
// - Without a valid lead index the lead moves to the next pump when a call follows all outputs off.
// - Under rotation the lead stays put while the all-off condition never occurs and the pump count is unchanged.
// - Rotation covers only the configured number of pumps, not a fixed eight.
// - A missing or out-of-range lead index falls back to automatic rotation.
// - The lead index in effect is kept in a register that can be read out.
module prls_pump_rotation_sequencer #(
	parameter int unsigned TICKS_PER_SEC = `PRLS_TICKS_PER_SEC
)(
	input  wire logic                          ref_clk,
	input  wire logic                          rst_n,
	input  wire logic [`PRLS_NUM_PUMPS-1:0]    pump_call_in,
	input  wire logic [`PRLS_CNT_W-1:0]        pump_count,
	input  wire logic [`PRLS_CNT_W-1:0]        lead_index,
	input  wire logic [`PRLS_SEC_W-1:0]        delay_sec,
	output logic      [`PRLS_NUM_PUMPS-1:0]    pump_call_out,
	output logic                               pump_call_out_first,
	output logic                               pump_call_out_last,
	output logic      [`PRLS_CNT_W-1:0]        lead_now,
	output logic      [`PRLS_SEC_W-1:0]        delay_secs_left,
	output logic                               delay_expired
);
	import prls_pkg::*;

	localparam int NP = `PRLS_NUM_PUMPS;

	// =============================================================
	// helpers

	// number of set bits in a pump vector
	function automatic logic [`PRLS_CNT_W-1:0] ones(
		input logic [`PRLS_NUM_PUMPS-1:0] v
	);
		logic [`PRLS_CNT_W-1:0] c;
		c = '0;
		for (int i = 0; i < NP; i++) begin
			c = c + `PRLS_CNT_W'(v[i]);
		end
		return c;
	endfunction

	// position of pump i in the calling order that starts at lead
	function automatic logic [`PRLS_CNT_W-1:0] rank(
		input int                         i,
		input logic [`PRLS_IDX_W-1:0]     lead,
		input logic [`PRLS_CNT_W-1:0]     n
	);
		int r;
		r = i - int'(lead);
		if (r < 0) begin
			r = r + int'(n);
		end
		if (i >= int'(n)) begin
			r = int'(`PRLS_RANK_NONE); // unconfigured pump sorts last
		end
		return `PRLS_CNT_W'(r);
	endfunction

	// =============================================================
	// reset release through two flip-flops
	logic rst_meta_q;
	logic rst_sync_q;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	// =============================================================
	// switching delay timer
	prls_tmr_if tif ();

	assign tif.clk       = ref_clk;
	assign tif.rst_n     = rst_sync_q;
	assign tif.delay_sec = delay_sec;

	prls_delay_timer #(
		.TICKS_PER_SEC (TICKS_PER_SEC)
	) u_timer (
		.t (tif)
	);

	// =============================================================
	// sequencer state
	prls_seq_state_t q;
	prls_seq_state_t d;

	logic [`PRLS_CNT_W-1:0]     n_cfg;
	logic [`PRLS_NUM_PUMPS-1:0] cfg_mask;
	logic [`PRLS_CNT_W-1:0]     n_calls;
	logic [`PRLS_CNT_W-1:0]     n_on;
	logic                       lead_ok;
	logic [`PRLS_IDX_W-1:0]     lead0;
	logic [`PRLS_NUM_PUMPS-1:0] want;
	logic                       advance;
	logic                       step;

	// =============================================================
	// configuration, call count and the wanted output pattern
	always_comb begin
		n_cfg = (pump_count > `PRLS_CNT_W'(NP)) ?
			`PRLS_CNT_W'(NP) : pump_count;
		for (int i = 0; i < NP; i++) begin
			cfg_mask[i] = (i < int'(n_cfg));
		end
		n_calls = ones(pump_call_in & cfg_mask);
		n_on    = ones(q.out);
		lead_ok = (lead_index != '0) && (lead_index <= n_cfg);
		if (lead_ok) begin
			lead0 = `PRLS_IDX_W'(lead_index - 1'b1);
		end else if (`PRLS_CNT_W'(q.rot) >= n_cfg) begin
			lead0 = '0;
		end else begin
			lead0 = q.rot;
		end
		for (int i = 0; i < NP; i++) begin
			want[i] = cfg_mask[i] &&
				(rank(i, lead0, n_cfg) < n_calls);
		end
	end

	// =============================================================
	// next state: rotation, then a single output step
	always_comb begin
		logic [`PRLS_CNT_W-1:0] best_on;
		logic [`PRLS_CNT_W-1:0] best_off;
		logic [`PRLS_CNT_W-1:0] r;
		int                     on_i;
		int                     off_i;
		best_on  = `PRLS_RANK_NONE;
		best_off = '0;
		r        = '0;
		on_i     = -1;
		off_i    = -1;
		d        = q;
		advance  = 1'b0;
		step     = 1'b0;

		// arm rotation while every output and every configured pump's call is off
		if ((q.out == '0) && (n_calls == '0)) begin
			d.armed = 1'b1;
		end

		// first call after all-off moves the lead on
		if (!lead_ok && q.armed && (q.out == '0) &&
			(n_calls != '0)) begin
			advance = 1'b1;
			d.armed = 1'b0;
			// step on from the lead in effect, so a stale index left
			// past a lowered pump count still moves to the next pump
			if (`PRLS_CNT_W'(lead0) + 1'b1 >= n_cfg) begin
				d.rot = '0;
			end else begin
				d.rot = lead0 + 1'b1;
			end
		end

		// lowest-ranked pump to start, highest-ranked pump to stop
		for (int i = 0; i < NP; i++) begin
			r = rank(i, lead0, n_cfg);
			if (want[i] && !q.out[i] && (r < best_on)) begin
				best_on = r;
				on_i    = i;
			end
			if (!want[i] && q.out[i] && (r >= best_off)) begin
				best_off = r;
				off_i    = i;
			end
		end

		// one change per expiry; stop first when at or over the count
		if (tif.expired && !advance && (q.out != want)) begin
			step = 1'b1;
			if ((off_i >= 0) && ((n_on >= n_calls) || (on_i < 0))) begin
				d.out[off_i] = 1'b0;
			end else if (on_i >= 0) begin
				d.out[on_i] = 1'b1;
			end else begin
				step = 1'b0;
			end
		end

		// observable lead and sequencer status
		d.lead = `PRLS_CNT_W'(lead0) + 1'b1;
		d.st   = (d.out == want) ? PRLS_SEQ_IDLE : PRLS_SEQ_WAIT;
	end

	// restart the delay on every output switch
	assign tif.restart = step;

	// =============================================================
	// state register
	always_ff @(posedge ref_clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			q.st    <= PRLS_SEQ_IDLE;
			q.out   <= `PRLS_RST_OUT;
			q.rot   <= `PRLS_RST_ROT;
			q.lead  <= `PRLS_RST_LEAD;
			q.armed <= 1'b0;
		end else begin
			q <= d;
		end
	end

	// =============================================================
	// outputs, all from registers
	assign pump_call_out       = q.out;
	assign pump_call_out_first = q.out[0];
	assign pump_call_out_last  = q.out[NP-1];
	assign lead_now            = q.lead;
	assign delay_secs_left     = tif.secs_left;
	assign delay_expired       = tif.expired;

endmodule

`default_nettype wire

// *** sim/prls_checker.sv ***
// port assertions for the pump rotation sequencer
`timescale 1ns/10ps
`default_nettype none

module prls_checker (
	input wire logic        ref_clk,
	input wire logic        rst_n,
	input wire logic [7:0]  pump_call_in,
	input wire logic [3:0]  pump_count,
	input wire logic [3:0]  lead_index,
	input wire logic [15:0] delay_sec,
	input wire logic [7:0]  pump_call_out,
	input wire logic        pump_call_out_first,
	input wire logic        pump_call_out_last,
	input wire logic [3:0]  lead_now,
	input wire logic [15:0] delay_secs_left,
	input wire logic        delay_expired
);
	logic [2:0] rs_q;
	logic [3:0] n, nc, on;

	// =========================================
	// helpers
	// ready once the internal reset copy is released
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			rs_q <= 3'h0;
		else
			rs_q <= {rs_q[1:0], 1'b1};
	end

	// calls among configured pumps and outputs now on
	always_comb begin
		n = (pump_count > 4'h8) ? 4'h8 : pump_count;
		nc = 4'h0;
		for (int i = 0; i < 8; i++)
			if (i < n && pump_call_in[i])
				nc = nc + 4'h1;
		on = 4'($countones(pump_call_out));
	end

	// =========================================
	// assertions
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rs_q[2]);

	sequence lead_held;
		lead_index != 4'h0 && lead_index <= n && $stable(lead_index)
			&& $stable(pump_count);
	endsequence

	AST_FIRST: assert property (
		pump_call_out_first == pump_call_out[0]) else $error("first bad");
	AST_LAST: assert property (
		pump_call_out_last == pump_call_out[7]) else $error("last bad");
	AST_ONE: assert property (
		$changed(pump_call_out) |->
		$onehot(pump_call_out ^ $past(pump_call_out))) else $error("two");
	AST_GATE: assert property (
		$changed(pump_call_out) |-> $past(delay_expired))
		else $error("switch before expiry");
	AST_RESTART: assert property (
		$changed(pump_call_out) |-> !delay_expired
		&& delay_secs_left == $past(delay_sec)) else $error("no restart");
	AST_EXPIRE: assert property (
		!delay_expired && delay_secs_left == 16'h0000 |=> delay_expired)
		else $error("expiry late");
	AST_ON_CNT: assert property (
		on > $past(on) |-> $past(on) < $past(nc)) else $error("extra on");
	AST_LEAD: assert property (
		lead_held [*3] |-> lead_now == lead_index) else $error("lead bad");
	AST_ROT_HOLD: assert property (
		$changed(lead_now) |-> $past(pump_call_out, 2) == 8'h00
		|| $past(lead_index) != $past(lead_index, 2)
		|| $past(pump_count) != $past(pump_count, 2))
		else $error("lead moved while pumps ran");
	AST_OFF_CNT: assert property (
		on < $past(on) |-> $past(on) >= $past(nc)) else $error("early off");
endmodule

`default_nettype wire

// *** sim/prls_call_src.sv ***
// upstream call source standing in for the pump controllers
`timescale 1ns/10ps
`default_nettype none

module prls_call_src (
	input wire logic       clk,
	input wire logic [3:0] n,
	input wire logic [3:0] want,
	output var logic [7:0] calls
);
	initial calls = 8'h00;

	// reshuffle which calls are up each cycle, count kept
	always @(negedge clk) begin
		logic [7:0] m, v;
		m = (8'h01 << n) - 8'h01;
		v = 8'($urandom) & ~m;
		while ($countones(v & m) < want)
			v[$urandom % n] = 1'b1;
		calls <= v;
	end
endmodule

`default_nettype wire

// *** sim/prls_pump_rotation_sequencer_tb.sv ***
// self-checking bench for the pump rotation sequencer
`timescale 1ns/10ps
`default_nettype none

module prls_pump_rotation_sequencer_tb;
	localparam int TPS = 4;
	logic        ref_clk = 1'b0, rst_n = 1'b0;
	logic [7:0]  pump_call_in, pump_call_out, o_neg = 8'h00;
	logic [3:0]  pump_count = 4'h4, lead_index = 4'h0, want = 4'h0;
	logic [3:0]  lead_now;
	logic [15:0] delay_sec = 16'h0001, delay_secs_left;
	logic        pump_call_out_first, pump_call_out_last, delay_expired;
	int          n_fail = 0, samples_checked = 0, cyc = 0, gap = 1000;
	int          live = 0, rot = 0, armed = 0, ml = 1, c_e = 0, n_e = 4;
	int          tbl [18][4] = '{'{4,0,1,2}, '{4,0,1,4}, '{4,0,1,1},
		'{4,0,1,0}, '{4,0,2,3}, '{4,0,1,0}, '{4,0,0,1}, '{4,0,1,0},
		'{4,0,1,1}, '{4,0,1,0}, '{4,0,1,1}, '{4,0,1,0}, '{3,2,0,2},
		'{3,2,0,0}, '{3,5,1,3}, '{3,0,1,0}, '{8,8,1,8}, '{8,8,1,0}};

	always #4 ref_clk = ~ref_clk;

	prls_pump_rotation_sequencer #(.TICKS_PER_SEC(TPS))
		prls_pump_rotation_sequencer_inst (
		.ref_clk(ref_clk), .rst_n(rst_n), .pump_call_in(pump_call_in),
		.pump_count(pump_count), .lead_index(lead_index),
		.delay_sec(delay_sec), .pump_call_out(pump_call_out),
		.pump_call_out_first(pump_call_out_first),
		.pump_call_out_last(pump_call_out_last), .lead_now(lead_now),
		.delay_secs_left(delay_secs_left), .delay_expired(delay_expired));
	prls_call_src prls_call_src_inst (.clk(ref_clk), .n(pump_count),
		.want(want), .calls(pump_call_in));

	// =========================================
	// reference model
	// pattern for c calls with lead l among n pumps
	function automatic logic [7:0] want_pat(int c, int l, int n);
		want_pat = 8'h00;
		for (int i = 0; i < n; i++)
			if ((i - l + 1 + n) % n < c)
				want_pat[i] = 1'b1;
	endfunction

	// one step towards the wanted pattern
	function automatic logic [7:0] nxt(logic [7:0] o, int c, int l, int n);
		logic [7:0] w;
		int r;
		bit on;
		w = want_pat(c, l, n);
		on = $countones(o) >= c;
		for (int k = 0; k < n; k++) begin
			r = (2 * n - 2 - k + l) % n; // highest rank first
			if (on && o[r] && !w[r])
				return o ^ (8'h01 << r);
			r = (k + l - 1) % n; // lowest rank first
			if (!on && !o[r] && w[r])
				return o ^ (8'h01 << r);
		end
		return o;
	endfunction

	task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic stop_test();
		if (n_fail == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// lead register model, call count and timeout
	always @(posedge ref_clk) begin
		int li;
		n_e = int'(pump_count);
		li = int'(lead_index);
		c_e = $countones(pump_call_in & ((8'h01 << n_e) - 8'h01));
		live = !rst_n ? 0 : (live < 3 ? live + 1 : 3);
		if (live < 3) begin
			rot = 0;
			armed = 0;
		end else if (!(li >= 1 && li <= n_e) && armed == 1
			&& o_neg == 8'h00 && c_e > 0) begin
			// an index past the pump count acts as pump one
			rot = ((rot >= n_e ? 0 : rot) + 1) % n_e;
			armed = 0;
		end else if (o_neg == 8'h00 && c_e == 0)
			armed = 1;
		ml = (li >= 1 && li <= n_e) ? li
			: (rot >= n_e ? 1 : rot + 1);
		cyc++;
		if (cyc > 20000) begin
			n_fail++;
			stop_test();
		end
	end

	// compare each output step with the model
	always @(negedge ref_clk) begin
		gap++;
		if (live >= 3 && pump_call_out !== o_neg) begin
			check("step", pump_call_out, nxt(o_neg, c_e, ml, n_e));
			check("lead", lead_now, ml);
			check("gap", gap > delay_sec * TPS, 1);
			gap = 0;
		end
		o_neg = pump_call_out;
	end

	// =========================================
	// stimulus
	// set configuration and call count, then let outputs settle
	task automatic apply(int n, int li, int d, int w);
		@(negedge ref_clk);
		pump_count = 4'(n);
		lead_index = 4'(li);
		delay_sec = 16'(d);
		want = 4'(w);
		repeat (9 * (d * TPS + 3)) @(negedge ref_clk);
		check("out", pump_call_out, want_pat(w, ml, n));
		check("lead", lead_now, ml);
	endtask

	initial begin
		void'($urandom(32'h6b36));
		repeat (2) @(posedge ref_clk);
		check("rst_out", pump_call_out, 8'h00);
		check("rst_lead", lead_now, 4'h1);
		@(negedge ref_clk);
		rst_n = 1'b1;
		foreach (tbl[i])
			apply(tbl[i][0], tbl[i][1], tbl[i][2], tbl[i][3]);
		repeat (6)
			apply(8, 0, $urandom % 2, $urandom % 9);
		stop_test();
	end
endmodule

bind prls_pump_rotation_sequencer prls_checker prls_checker_inst (
	.ref_clk(ref_clk), .rst_n(rst_n), .pump_call_in(pump_call_in),
	.pump_count(pump_count), .lead_index(lead_index),
	.delay_sec(delay_sec), .pump_call_out(pump_call_out),
	.pump_call_out_first(pump_call_out_first),
	.pump_call_out_last(pump_call_out_last), .lead_now(lead_now),
	.delay_secs_left(delay_secs_left), .delay_expired(delay_expired));

`default_nettype wire
